// ---- rtl/uec_consts.svh ----
`ifndef UEC_CONSTS_SVH
`define UEC_CONSTS_SVH

// sizes
`define UEC_N_CTR 4
`define UEC_N_EV 8
`define UEC_LANES 8
`define UEC_CTR_W 48
`define UEC_N_SLICE 40
`define UEC_CAP_HI_W 9

// unit-relative register offsets
`define UEC_ADDR_UNIT_CTL 12'h000
`define UEC_ADDR_CTL0 12'h001
`define UEC_ADDR_UNIT_STATUS 12'h007
`define UEC_ADDR_CTR0 12'h008
`define UEC_ADDR_CAP_LO 12'h09C
`define UEC_ADDR_CAP_HI 12'h0A0

// field positions
`define UEC_CTL_CLEAR_BIT 17
`define UEC_UNIT_EN_BIT 0

// reserved bits and the write-only clear bit are never stored
`define UEC_CTL_WMASK 32'hFFD4FFFF

// reset values
`define UEC_CTL_RESET 32'h00000000
`define UEC_UNIT_EN_RESET 1'h0
`define UEC_CTR_RESET 48'h000000000000

`endif

// ---- rtl/uec_pkg.sv ----
package uec_pkg;

    // counter_control_word layout, identical in every unit
    typedef struct packed {
        logic [7:0] compare_level;
        logic       compare_flip;
        logic       local_enable;
        logic       rsv21;
        logic       wrap_notify_enable;
        logic       rsv19;
        logic       rising_only;
        logic       counter_clear;
        logic       rsv16;
        logic [7:0] subevent_mask;
        logic [7:0] event_select;
    } uec_ctl_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [63:0] wdata;
    } uec_req_s;

endpackage : uec_pkg

// ---- rtl/uec_slice_cap.sv ----
`include "uec_consts.svh"

module uec_slice_cap (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic [`UEC_N_SLICE-1:0] slice_present, // one bit per slice with its agent
    output logic [31:0] cap_lo_ff, // low capability word
    output logic [`UEC_CAP_HI_W-1:0] cap_hi_ff // high capability word, bits 8:0
);
    // sampled each cycle: presence is a strap-like level, never captured under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_lo_ff <= 32'h00000000;
            cap_hi_ff <= 9'h000;
        end else begin
            cap_lo_ff <= slice_present[31:0];
            cap_hi_ff <= {1'b0, slice_present[39:32]};
        end
    end
endmodule : uec_slice_cap

// ---- rtl/uec_counter.sv ----
`include "uec_consts.svh"

module uec_counter (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire uec_pkg::uec_ctl_s ctl, // paired control word
    input wire logic [`UEC_N_EV*`UEC_LANES-1:0] ev_lanes, // subevent lanes of all events
    input wire logic count_en, // enabled at every level
    input wire logic clr, // clear pulse
    input wire logic ld, // software load pulse
    input wire logic [`UEC_CTR_W-1:0] ld_data, // load value
    output logic [`UEC_CTR_W-1:0] count_ff, // event count
    output logic wrap // carry out of bit 47 this cycle
);
    logic [`UEC_LANES-1:0] lanes;
    logic [3:0] inc_raw;
    logic qual;
    logic fire;
    logic prev_ff;
    logic [3:0] inc;
    logic [`UEC_CTR_W:0] sum;

    always_comb begin
        lanes = '0;
        if (ctl.event_select < 8'(`UEC_N_EV)) begin
            lanes = ev_lanes[ctl.event_select[2:0]*`UEC_LANES +: `UEC_LANES] & ctl.subevent_mask;
        end
        inc_raw = 4'h0;
        for (int k = 0; k < `UEC_LANES; k++) begin
            inc_raw = inc_raw + {3'h0, lanes[k]};
        end
    end

    // threshold first, then flip and edge, so edge needs a nonzero level
    assign qual = ctl.compare_flip ? ({4'h0, inc_raw} < ctl.compare_level)
                                   : ({4'h0, inc_raw} >= ctl.compare_level);
    assign fire = ctl.rising_only ? (qual & ~prev_ff) : qual;
    assign inc = (ctl.compare_level == 8'h00) ? inc_raw : {3'h0, fire};
    assign sum = {1'b0, count_ff} + {45'h0, inc};
    assign wrap = count_en & sum[`UEC_CTR_W] & ~clr & ~ld;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= qual;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_ff <= `UEC_CTR_RESET;
        end else if (clr) begin
            count_ff <= `UEC_CTR_RESET;
        end else if (ld) begin
            count_ff <= ld_data;
        end else if (count_en) begin
            count_ff <= sum[`UEC_CTR_W-1:0];
        end
    end

    AST_THRESH_ONE : assert property (@(posedge clk) disable iff (rst)
        count_en && !clr && !ld && ctl.compare_level != 8'h00 && !ctl.compare_flip && !ctl.rising_only
        && {4'h0, inc_raw} >= ctl.compare_level |=> count_ff == $past(count_ff) + 48'h1)
        else $error("threshold hit did not add exactly one");

    AST_FLIP : assert property (@(posedge clk) disable iff (rst)
        count_en && !clr && !ld && ctl.compare_level != 8'h00 && ctl.compare_flip && !ctl.rising_only
        && {4'h0, inc_raw} >= ctl.compare_level |=> count_ff == $past(count_ff))
        else $error("flipped compare counted a high level");

    // the guard sits on the second cycle, where a load or clear would move the count
    sequence s_held_level;
        qual ##1 (qual && ctl.rising_only && ctl.compare_level != 8'h00 && !clr && !ld);
    endsequence

    AST_EDGE : assert property (@(posedge clk) disable iff (rst)
        s_held_level |=> count_ff == $past(count_ff))
        else $error("rising mode counted a held level");
endmodule : uec_counter

// ---- rtl/uec_unit.sv ----
`include "uec_consts.svh"

module uec_unit #(
    parameter logic [5:0] UNIT_ID = 6'h00 // unit number carried in wrap messages
) (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    input wire logic [11:0] reg_addr, // register offset
    input wire logic [63:0] reg_wdata, // write data
    output logic [63:0] reg_rdata_ff, // read data
    output logic reg_rvalid_ff, // read data valid pulse
    input wire logic [`UEC_N_EV*`UEC_LANES-1:0] ev_lanes, // subevent lanes, 8 per event
    input wire logic global_count_en, // global enable from the hub, low when frozen
    input wire logic [`UEC_N_SLICE-1:0] slice_present, // slice presence straps
    output logic wrap_msg_valid_ff, // wrap message pulse to the hub
    output logic [5:0] wrap_msg_unit_ff, // unit named by the message
    output logic [`UEC_N_CTR-1:0] unit_wrap_flag_ff // sticky wrap flags
);
    uec_pkg::uec_req_s req;
    uec_pkg::uec_ctl_s ctl_ff [`UEC_N_CTR];
    logic unit_en_ff;
    logic [`UEC_CTR_W-1:0] count [`UEC_N_CTR];
    logic [`UEC_N_CTR-1:0] wrap_vec;
    logic [`UEC_N_CTR-1:0] notify_vec;
    logic [`UEC_N_CTR-1:0] clr_vec;
    logic [`UEC_N_CTR-1:0] ld_vec;
    logic [`UEC_N_CTR-1:0] ctl_wr_vec;
    logic [`UEC_N_CTR-1:0] en_vec;
    logic [`UEC_N_CTR-1:0] clear_mask;
    logic [`UEC_N_CTR-1:0] nxt_unit_wrap_flag;
    logic [31:0] cap_lo_ff;
    logic [`UEC_CAP_HI_W-1:0] cap_hi_ff;
    logic [63:0] nxt_reg_rdata;
    logic status_wr;
    logic unit_ctl_wr;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign status_wr = req.wr && req.addr == `UEC_ADDR_UNIT_STATUS;
    assign unit_ctl_wr = req.wr && req.addr == `UEC_ADDR_UNIT_CTL;

    uec_slice_cap u_cap (
        .clk(clk),
        .rst(rst),
        .slice_present(slice_present),
        .cap_lo_ff(cap_lo_ff),
        .cap_hi_ff(cap_hi_ff)
    );

    genvar i;
    generate
        for (i = 0; i < `UEC_N_CTR; i++) begin : g_ctr
            assign ctl_wr_vec[i] = req.wr && req.addr == 12'(`UEC_ADDR_CTL0 + i);
            // the clear bit acts on the write and is never stored, so it reads back as zero
            assign clr_vec[i] = ctl_wr_vec[i] && req.wdata[`UEC_CTL_CLEAR_BIT];
            assign ld_vec[i] = req.wr && req.addr == 12'(`UEC_ADDR_CTR0 + i);
            assign en_vec[i] = global_count_en && unit_en_ff && ctl_ff[i].local_enable;
            assign notify_vec[i] = ctl_ff[i].wrap_notify_enable;

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ctl_ff[i] <= uec_pkg::uec_ctl_s'(`UEC_CTL_RESET);
                end else if (ctl_wr_vec[i]) begin
                    ctl_ff[i] <= uec_pkg::uec_ctl_s'(req.wdata[31:0] & `UEC_CTL_WMASK);
                end
            end

            uec_counter u_ctr (
                .clk(clk),
                .rst(rst),
                .ctl(ctl_ff[i]),
                .ev_lanes(ev_lanes),
                .count_en(en_vec[i]),
                .clr(clr_vec[i]),
                .ld(ld_vec[i]),
                .ld_data(req.wdata[`UEC_CTR_W-1:0]),
                .count_ff(count[i]),
                .wrap(wrap_vec[i])
            );

            AST_CLEAR : assert property (@(posedge clk) disable iff (rst)
                clr_vec[i] |=> count[i] == 48'h0 && ctl_ff[i].counter_clear == 1'b0)
                else $error("counter clear bit did not zero the counter");

            AST_LOCAL_OFF : assert property (@(posedge clk) disable iff (rst)
                !ctl_ff[i].local_enable && !clr_vec[i] && !ld_vec[i] |=> count[i] == $past(count[i]))
                else $error("counter moved with its local enable off");

            AST_CTR_FLAG : assert property (@(posedge clk) disable iff (rst)
                wrap_vec[i]
                |=> unit_wrap_flag_ff[i])
                else $error("counter wrap left its flag clear");

            AST_CTR_NOTIFY : assert property (@(posedge clk) disable iff (rst)
                wrap_vec[i] && ctl_ff[i].wrap_notify_enable
                |=> wrap_msg_valid_ff)
                else $error("notified counter wrap sent no message");

            AST_LOCAL_NO_WRAP : assert property (@(posedge clk) disable iff (rst)
                !ctl_ff[i].local_enable
                |-> !wrap_vec[i])
                else $error("wrap seen with local enable off");

            AST_GLOBAL_NO_WRAP : assert property (@(posedge clk) disable iff (rst)
                !global_count_en
                |-> !wrap_vec[i])
                else $error("wrap seen while globally frozen");

            AST_UNIT_OFF : assert property (@(posedge clk) disable iff (rst)
                !unit_en_ff && !clr_vec[i] && !ld_vec[i]
                |=> count[i] == $past(count[i]))
                else $error("counter moved with the unit disabled");

            AST_LOAD : assert property (@(posedge clk) disable iff (rst)
                ld_vec[i] && !clr_vec[i]
                |=> count[i] == $past(req.wdata[`UEC_CTR_W-1:0]))
                else $error("counter load did not land");

            AST_CTL_RSV : assert property (@(posedge clk) disable iff (rst)
                !ctl_ff[i].rsv21 && !ctl_ff[i].rsv19
                && !ctl_ff[i].rsv16 && !ctl_ff[i].counter_clear)
                else $error("reserved control bit stored");

            AST_CTL_WRITE : assert property (@(posedge clk) disable iff (rst)
                ctl_wr_vec[i]
                |=> ctl_ff[i].event_select == $past(req.wdata[7:0])
                && ctl_ff[i].subevent_mask == $past(req.wdata[15:8]))
                else $error("event select or mask not stored");

            AST_CTL_HOLD : assert property (@(posedge clk) disable iff (rst)
                !ctl_wr_vec[i]
                |=> $stable(ctl_ff[i]))
                else $error("control word changed without a write");
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_en_ff <= `UEC_UNIT_EN_RESET;
        end else if (unit_ctl_wr) begin
            unit_en_ff <= req.wdata[`UEC_UNIT_EN_BIT];
        end
    end

    // a wrap in the same cycle as a write-one clear keeps the flag set
    assign clear_mask = status_wr ? req.wdata[`UEC_N_CTR-1:0] : '0;
    assign nxt_unit_wrap_flag = (unit_wrap_flag_ff & ~clear_mask) | wrap_vec;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_wrap_flag_ff <= '0;
        end else begin
            unit_wrap_flag_ff <= nxt_unit_wrap_flag;
        end
    end

    // one message per cycle in which a notify-enabled counter wraps; the hub itself holds off further freezes until cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrap_msg_valid_ff <= 1'b0;
            wrap_msg_unit_ff <= UNIT_ID;
        end else begin
            wrap_msg_valid_ff <= |(wrap_vec & notify_vec);
            wrap_msg_unit_ff <= UNIT_ID;
        end
    end

    always_comb begin
        nxt_reg_rdata = 64'h0000000000000000;
        if (req.addr == `UEC_ADDR_UNIT_CTL) begin
            nxt_reg_rdata[`UEC_UNIT_EN_BIT] = unit_en_ff;
        end else if (req.addr == `UEC_ADDR_UNIT_STATUS) begin
            nxt_reg_rdata[`UEC_N_CTR-1:0] = unit_wrap_flag_ff;
        end else if (req.addr == `UEC_ADDR_CAP_LO) begin
            nxt_reg_rdata[31:0] = cap_lo_ff;
        end else if (req.addr == `UEC_ADDR_CAP_HI) begin
            nxt_reg_rdata[`UEC_CAP_HI_W-1:0] = cap_hi_ff;
        end
        for (int k = 0; k < `UEC_N_CTR; k++) begin
            if (req.addr == 12'(`UEC_ADDR_CTL0 + k)) begin
                nxt_reg_rdata[31:0] = ctl_ff[k];
            end
            if (req.addr == 12'(`UEC_ADDR_CTR0 + k)) begin
                nxt_reg_rdata[`UEC_CTR_W-1:0] = count[k];
            end
        end
    end

    // unmapped reads answer zero; rdata holds until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 64'h0000000000000000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= req.rd;
            if (req.rd) begin
                reg_rdata_ff <= nxt_reg_rdata;
            end
        end
    end

    // checks

    sequence s_notified_wrap;
        |(wrap_vec & notify_vec);
    endsequence

    sequence s_message_out;
        wrap_msg_valid_ff && wrap_msg_unit_ff == UNIT_ID;
    endsequence

    AST_FLAG_SET : assert property (@(posedge clk) disable iff (rst)
        |wrap_vec |=> (unit_wrap_flag_ff & $past(wrap_vec)) == $past(wrap_vec))
        else $error("wrap did not set its unit wrap flag");

    AST_MSG_SENT : assert property (@(posedge clk) disable iff (rst)
        s_notified_wrap |=> s_message_out)
        else $error("notified wrap sent no message");

    AST_MSG_QUIET : assert property (@(posedge clk) disable iff (rst)
        !(|(wrap_vec & notify_vec)) |=> !wrap_msg_valid_ff)
        else $error("message without a notified wrap");

    AST_FLAG_HOLD : assert property (@(posedge clk) disable iff (rst)
        (|unit_wrap_flag_ff) && !status_wr |=> (unit_wrap_flag_ff & $past(unit_wrap_flag_ff))
        == $past(unit_wrap_flag_ff))
        else $error("wrap flag dropped without a clearing write");

    AST_W1C : assert property (@(posedge clk) disable iff (rst)
        status_wr && wrap_vec == '0 |=> (unit_wrap_flag_ff & $past(req.wdata[`UEC_N_CTR-1:0])) == '0)
        else $error("write of one did not clear the wrap flag");

    AST_SET_WINS : assert property (@(posedge clk) disable iff (rst)
        status_wr && (|wrap_vec) |=> (unit_wrap_flag_ff & $past(wrap_vec)) == $past(wrap_vec))
        else $error("clear overrode a same-cycle wrap");

    AST_FROZEN : assert property (@(posedge clk) disable iff (rst)
        !global_count_en && !(|clr_vec) && !(|ld_vec) |=> count[0] == $past(count[0])
        && count[`UEC_N_CTR-1] == $past(count[`UEC_N_CTR-1]))
        else $error("counter moved while globally frozen");

    AST_WRAP_LOW : assert property (@(posedge clk) disable iff (rst)
        wrap_vec[0] |=> count[0] < 48'h000000000009)
        else $error("counter did not wrap to a low value");

    AST_CAP_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `UEC_ADDR_CAP_HI |=> reg_rvalid_ff
        && reg_rdata_ff == {55'h0, $past(cap_hi_ff)})
        else $error("high capability word read wrong");

    AST_RD_TIMING : assert property (@(posedge clk) disable iff (rst)
        reg_rvalid_ff |-> $past(req.rd))
        else $error("read valid without a read");

    AST_MSG_ID : assert property (@(posedge clk) disable iff (rst)
        wrap_msg_valid_ff
        |-> wrap_msg_unit_ff == UNIT_ID)
        else $error("wrap message named another unit");

    AST_FLAG_SOURCE : assert property (@(posedge clk) disable iff (rst)
        !rst
        |=> (unit_wrap_flag_ff & ~$past(unit_wrap_flag_ff) & ~$past(wrap_vec)) == '0)
        else $error("wrap flag set without a wrap");

    AST_ZERO_WRITE : assert property (@(posedge clk) disable iff (rst)
        status_wr && req.wdata[`UEC_N_CTR-1:0] == 4'h0
        |=> (unit_wrap_flag_ff & $past(unit_wrap_flag_ff)) == $past(unit_wrap_flag_ff))
        else $error("write of zero cleared a wrap flag");

    AST_UNIT_EN_WR : assert property (@(posedge clk) disable iff (rst)
        unit_ctl_wr
        |=> unit_en_ff == $past(req.wdata[`UEC_UNIT_EN_BIT]))
        else $error("unit enable write did not land");

    AST_UNIT_EN_HOLD : assert property (@(posedge clk) disable iff (rst)
        !unit_ctl_wr
        |=> $stable(unit_en_ff))
        else $error("unit enable changed without a write");

    AST_RVALID_PULSE : assert property (@(posedge clk) disable iff (rst)
        !req.rd
        |=> !reg_rvalid_ff)
        else $error("read valid without a read strobe");

    AST_RDATA_HOLD : assert property (@(posedge clk) disable iff (rst)
        !req.rd
        |=> $stable(reg_rdata_ff))
        else $error("read data changed without a read");

    AST_CAP_LO_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `UEC_ADDR_CAP_LO
        |=> reg_rdata_ff == {32'h0, $past(cap_lo_ff)})
        else $error("low capability word read wrong");

    AST_CAP_TOP_ZERO : assert property (@(posedge clk) disable iff (rst)
        !rst
        |-> !cap_hi_ff[`UEC_CAP_HI_W-1])
        else $error("capability bit above the slice vector set");

    // presence straps are not reset, so the attempt starts only once reset is gone
    AST_CAP_LO_TRACK : assert property (@(posedge clk) disable iff (rst)
        !rst
        |=> cap_lo_ff == $past(slice_present[31:0]))
        else $error("low capability word lost a slice");

    AST_CAP_HI_TRACK : assert property (@(posedge clk) disable iff (rst)
        !rst
        |=> cap_hi_ff[7:0] == $past(slice_present[`UEC_N_SLICE-1:32]))
        else $error("high capability word lost a slice");

    AST_STATUS_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `UEC_ADDR_UNIT_STATUS
        |=> reg_rdata_ff == {60'h0, $past(unit_wrap_flag_ff)})
        else $error("unit status read wrong");

    AST_UNMAPPED_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && (req.addr == 12'h005 || req.addr == 12'h006)
        |=> reg_rdata_ff == 64'h0000000000000000)
        else $error("unmapped read returned data");

    AST_FROZEN_QUIET : assert property (@(posedge clk) disable iff (rst)
        !global_count_en
        |=> !wrap_msg_valid_ff)
        else $error("wrap message while globally frozen");

    AST_CTL0_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `UEC_ADDR_CTL0
        |=> reg_rdata_ff == {32'h0, $past(ctl_ff[0])})
        else $error("control word read wrong");

    AST_CTR0_READ : assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == `UEC_ADDR_CTR0
        |=> reg_rdata_ff == {16'h0, $past(count[0])})
        else $error("counter read wrong");
endmodule : uec_unit

// ---- verification/uec_hub_model.sv ----
module uec_hub_model (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic msg_valid, // wrap message pulse from a unit
    input wire logic [5:0] msg_unit, // unit named by the message
    input wire logic sw_en, // software global enable
    input wire logic [63:0] gclr, // write-one-to-clear of global flags
    output logic global_count_en, // enable to every unit
    output logic [63:0] global_unit_wrap_flag_ff, // one flag per unit
    output logic monitor_interrupt_ff // interrupt pulse on each freeze
);
    timeunit 1ns;
    timeprecision 1ps;

    logic frozen_ff;
    logic fresh;

    // a unit whose global flag is still set cannot freeze again
    assign fresh = msg_valid & ~global_unit_wrap_flag_ff[msg_unit];
    assign global_count_en = sw_en & ~frozen_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_unit_wrap_flag_ff <= 64'h0;
        end else begin
            global_unit_wrap_flag_ff <= (global_unit_wrap_flag_ff & ~gclr)
                | (msg_valid ? (64'h1 << msg_unit) : 64'h0);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frozen_ff <= 1'h0;
        end else if (!sw_en) begin
            frozen_ff <= 1'h0;
        end else if (fresh) begin
            frozen_ff <= 1'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            monitor_interrupt_ff <= 1'h0;
        end else begin
            monitor_interrupt_ff <= fresh;
        end
    end
endmodule : uec_hub_model

// ---- verification/uec_unit_tb.sv ----
`include "uec_consts.svh"

module uec_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0;
    logic rst = 1'h1;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [63:0] reg_wdata = 64'h0;
    logic [63:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    logic [63:0] ev_lanes = 64'h0;
    logic global_count_en;
    logic [39:0] slice_present = 40'hA512340F0F;
    logic wrap_msg_valid_ff;
    logic [5:0] wrap_msg_unit_ff;
    logic [3:0] unit_wrap_flag_ff;
    logic sw_en = 1'h0;
    logic [63:0] gclr = 64'h0;
    logic [63:0] gflags;
    logic irq;
    int miscompares = 0;
    int total_checks = 0;
    int n_msg = 0;
    int n_irq = 0;
    logic [47:0] exp_cnt;
    logic [7:0] t_lanes [5] = '{8'h07, 8'h03, 8'h01, 8'h01, 8'h03};
    logic t_flip [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
    int t_n [5] = '{4, 2, 3, 3, 2};
    int t_inc [5] = '{1, 1, 0, 1, 0};

    always #5 clk = ~clk;

    uec_unit #(.UNIT_ID(6'h05)) u_uec_unit (
        .clk(clk),
        .rst(rst),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff),
        .ev_lanes(ev_lanes),
        .global_count_en(global_count_en),
        .slice_present(slice_present),
        .wrap_msg_valid_ff(wrap_msg_valid_ff),
        .wrap_msg_unit_ff(wrap_msg_unit_ff),
        .unit_wrap_flag_ff(unit_wrap_flag_ff)
    );

    uec_hub_model u_uec_hub_model (
        .clk(clk),
        .rst(rst),
        .msg_valid(wrap_msg_valid_ff),
        .msg_unit(wrap_msg_unit_ff),
        .sw_en(sw_en),
        .gclr(gclr),
        .global_count_en(global_count_en),
        .global_unit_wrap_flag_ff(gflags),
        .monitor_interrupt_ff(irq)
    );

    always @(posedge clk) begin
        if (wrap_msg_valid_ff === 1'h1) n_msg++;
        if (irq === 1'h1) n_irq++;
    end

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr

    task rd_chk(input logic [11:0] a, input logic [63:0] exp);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk({63'h0, reg_rvalid_ff}, 64'h1);
        chk(reg_rdata_ff, exp);
    endtask : rd_chk

    // lanes settle while sw_en is low, then sw_en is held high for exactly n edges; a hub freeze can close the global enable sooner
    task run_ev(input logic [63:0] lanes, input int n);
        @(posedge clk);
        ev_lanes <= lanes;
        @(posedge clk);
        sw_en <= 1'h1;
        repeat (n) @(posedge clk);
        sw_en <= 1'h0;
        #1;
    endtask : run_ev

    // event 1, local enable set
    function automatic logic [63:0] cw(input logic [7:0] lvl, input logic flip, input logic rise, input logic ntf,
                                       input logic [7:0] mask);
        return {32'h0, lvl, flip, 1'h1, 1'h0, ntf, 1'h0, rise, 2'h0, mask, 8'h01};
    endfunction : cw

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        rd_chk(12'h09C, 64'h12340F0F);
        rd_chk(12'h0A0, 64'hA5);
        rd_chk(12'h001, 64'h0);
        rd_chk(12'h0FF, 64'h0);
        wr(12'h09C, 64'h0);
        rd_chk(12'h09C, 64'h12340F0F);
        wr(12'h002, 64'hFFFFFFFF);
        rd_chk(12'h002, {32'h0, `UEC_CTL_WMASK});
        wr(12'h000, 64'h1);
        wr(12'h001, cw(8'h00, 1'h0, 1'h0, 1'h0, 8'h05));
        run_ev(64'h0FFF, 5);
        rd_chk(12'h008, 64'hA);
        repeat (3) @(posedge clk);
        rd_chk(12'h008, 64'hA);
        wr(12'h000, 64'h0);
        run_ev(64'h0FFF, 3);
        rd_chk(12'h008, 64'hA);
        wr(12'h000, 64'h1);
        wr(12'h001, cw(8'h00, 1'h0, 1'h0, 1'h0, 8'h05) & 64'hFFFFFFFFFFBFFFFF);
        run_ev(64'h0FFF, 3);
        rd_chk(12'h008, 64'hA);
        wr(12'h001, cw(8'h02, 1'h0, 1'h0, 1'h0, 8'hFF) | 64'h20000);
        rd_chk(12'h008, 64'h0);
        rd_chk(12'h001, cw(8'h02, 1'h0, 1'h0, 1'h0, 8'hFF));
        exp_cnt = 48'h0;
        for (int i = 0; i < 5; i++) begin
            wr(12'h001, cw(8'h02, t_flip[i], 1'h0, 1'h0, 8'hFF));
            run_ev({48'h0, t_lanes[i], 8'h00}, t_n[i]);
            exp_cnt = exp_cnt + 48'(t_inc[i] * t_n[i]);
            rd_chk(12'h008, {16'h0, exp_cnt});
        end
        // rising mode: three pulses of two active cycles count three, not six
        wr(12'h001, cw(8'h01, 1'h0, 1'h1, 1'h0, 8'hFF) | 64'h20000);
        @(posedge clk);
        ev_lanes <= 64'h0;
        sw_en <= 1'h1;
        repeat (3) begin
            @(posedge clk);
            ev_lanes <= 64'h0100;
            @(posedge clk);
            ev_lanes <= 64'h0300;
            @(posedge clk);
            ev_lanes <= 64'h0;
        end
        @(posedge clk);
        sw_en <= 1'h0;
        rd_chk(12'h008, 64'h3);
        wr(12'h008, 64'hFFFFFFFFFFFE);
        wr(12'h001, cw(8'h00, 1'h0, 1'h0, 1'h1, 8'h01));
        run_ev(64'h0100, 10);
        rd_chk(12'h008, 64'h1);
        chk(64'(n_msg), 64'h1);
        chk({58'h0, wrap_msg_unit_ff}, 64'h5);
        chk(gflags, 64'h20);
        chk(64'(n_irq), 64'h1);
        rd_chk(12'h007, 64'h1);
        wr(12'h007, 64'h0);
        rd_chk(12'h007, 64'h1);
        wr(12'h007, 64'h1);
        rd_chk(12'h007, 64'h0);
        @(posedge clk);
        gclr <= 64'h20;
        @(posedge clk);
        gclr <= 64'h0;
        #1;
        chk(gflags, 64'h0);
        run_ev(64'h0100, 4);
        rd_chk(12'h008, 64'h5);
        wr(12'h009, 64'hFFFFFFFFFFFF);
        wr(12'h002, cw(8'h00, 1'h0, 1'h0, 1'h0, 8'h01));
        run_ev(64'h0100, 1);
        chk({60'h0, unit_wrap_flag_ff}, 64'h2);
        rd_chk(12'h009, 64'h0);
        chk(64'(n_msg), 64'h1);
        end_sim();
    end
endmodule : uec_unit_tb
